// ===== pie_bank.sv
/*
 * peripheral interrupt enable and flag bank: two enable registers, two
 * latched flag registers, the core gate bits and the request to the core.
 * assumes one 200 MHz clock, event pulses synchronous to it, and a master
 * that issues one-cycle strobes and never waits.
 *
 * register map on the plain port (index, content):
 *   0  enable bank one, all eight bits writable
 *   1  enable bank two, bits three and one tied to zero
 *   2  flag bank one, bits five and four are live serial mirrors
 *   3  flag bank two, bits three and one tied to zero
 *   4  core gate bits, seven global and six peripheral
 *   other indices ignore writes and read as zero
 * flags may also be set by software writing ones; that is deliberate,
 * it lets firmware exercise its handlers without the peripheral.
 * the comparator history clears in reset, so a high comparator level at
 * release is seen as one change and sets its flag once.
 */
// Chosen here: the placing of the registers and strobed register access.
// Notes on behaviour
// - peripheral gate must be set for any request
// - enable bank one: eeprom adc rx tx ssp cc1 t2 t1
// - enable bank two: osc cmpb cmpa lcd lvd cc2
// - bank two bits three and one read zero
// - flags set regardless of enables and gates
// - eeprom flag set on write done, software clears
// - adc flag set on conversion done, software clears
// - rx flag mirrors full buffer, read clears
// - tx flag mirrors empty buffer, write clears
// - ssp flag set on transfer done
// - capture/compare flags set only in capture and compare mode
// - timer2 flag set on period match
// - timer1 flag set on counter overflow
// - oscillator fail flag set, software clears
// - comparator flags set on output change
// - lcd and low voltage flags set on request
// - global gate blocks the core request only, peripheral gate both requests
`timescale 1ns/10ps
`include "pie_defs.svh"

module pie_bank
  import pie_pkg::*;
(
  // clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_n_in,
  // register port
  input  wire pie_req_s     req_in,
  output logic [7:0]        rdata_out,
  // peripheral events and levels
  input  wire pie_evt_s     evt_in,
  input  wire pie_cc_mode_e cc1_mode_in,
  input  wire pie_cc_mode_e cc2_mode_in,
  input  wire logic         serial_rx_full_in,
  input  wire logic         serial_tx_empty_in,
  input  wire logic         comparator_a_output_in,
  input  wire logic         comparator_b_output_in,
  // serial data register access side effects
  output logic              serial_rx_data_rd_out,
  output logic              serial_tx_data_wr_out,
  // requests to the core
  output logic              periph_irq_out,
  output logic              core_irq_out
);

  // ============================================================
  // register state
  logic [7:0] en1_q;
  logic [7:0] en2_q;
  logic [7:0] flg1_q;
  logic [7:0] flg1_d;
  logic [7:0] flg2_q;
  logic [7:0] flg2_d;
  logic [7:0] core_q;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] flg1_rd;
  logic       cmpa_q;
  logic       cmpb_q;
  logic       wr_en1;
  logic       wr_en2;
  logic       wr_flg1;
  logic       wr_flg2;
  logic       wr_core;
  logic       periph_pend;

  // write decode
  assign wr_en1  = req_in.wr && (req_in.addr == `PIE_OFS_EN1);
  assign wr_en2  = req_in.wr && (req_in.addr == `PIE_OFS_EN2);
  assign wr_flg1 = req_in.wr && (req_in.addr == `PIE_OFS_FLG1);
  assign wr_flg2 = req_in.wr && (req_in.addr == `PIE_OFS_FLG2);
  assign wr_core = req_in.wr && (req_in.addr == `PIE_OFS_CORE);

  // ============================================================
  // enable registers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      en1_q <= `PIE_RST_VAL;
      en2_q <= `PIE_RST_VAL;
    end else begin
      if (wr_en1) begin
        en1_q <= req_in.wdata;
      end
      if (wr_en2) begin
        en2_q <= req_in.wdata & `PIE_MASK2;
      end
    end
  end

  // core gate bits; only global and peripheral gate live here
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      core_q <= `PIE_RST_VAL;
    end else if (wr_core) begin
      core_q <= req_in.wdata & `PIE_MASK_CORE;
    end
  end

  // comparator output history for change detection
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cmpa_q <= 1'b0;
      cmpb_q <= 1'b0;
    end else begin
      cmpa_q <= comparator_a_output_in;
      cmpb_q <= comparator_b_output_in;
    end
  end

  // ============================================================
  // hardware set terms, blind to enables and gates
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    set1[`PIE_B1_EEPROM] = evt_in.eeprom_done;
    set1[`PIE_B1_ADC]    = evt_in.adc_done;
    set1[`PIE_B1_SSP]    = evt_in.ssp_done;
    set1[`PIE_B1_CC1]    = evt_in.cc1_event && (cc1_mode_in == PIE_CC_CAPTURE
                           || cc1_mode_in == PIE_CC_COMPARE);
    set1[`PIE_B1_TMR2]   = evt_in.tmr2_match;
    set1[`PIE_B1_TIMER1_COUNTER]   = evt_in.timer1_counter_overflow;
    set2[`PIE_B2_OSC]    = evt_in.osc_fail;
    set2[`PIE_B2_CMPB]   = comparator_b_output_in != cmpb_q;
    set2[`PIE_B2_CMPA]   = comparator_a_output_in != cmpa_q;
    set2[`PIE_B2_LCD]    = evt_in.lcd_req;
    set2[`PIE_B2_LVD]    = evt_in.lvd_req;
    set2[`PIE_B2_CC2]    = evt_in.cc2_event && (cc2_mode_in == PIE_CC_CAPTURE
                           || cc2_mode_in == PIE_CC_COMPARE);
  end

  // next flag values; a write may clear or set, but a set event always wins
  always_comb begin
    flg1_d = flg1_q;
    flg2_d = flg2_q;
    if (wr_flg1) begin
      flg1_d = (flg1_q & ~`PIE_WMASK_FLG1) | (req_in.wdata & `PIE_WMASK_FLG1);
    end
    if (wr_flg2) begin
      flg2_d = req_in.wdata & `PIE_MASK2;
    end
    flg1_d = flg1_d | set1;
    flg2_d = (flg2_d | set2) & `PIE_MASK2;
  end

  // ============================================================
  // latched flag registers; rx and tx bits are not stored
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      flg1_q <= `PIE_RST_VAL;
      flg2_q <= `PIE_RST_VAL;
    end else begin
      flg1_q <= flg1_d & `PIE_WMASK_FLG1;
      flg2_q <= flg2_d;
    end
  end

  // serial bits are live mirrors of the buffer state, so the serial
  // block itself clears them on a data register read or write
  always_comb begin
    flg1_rd = flg1_q;
    flg1_rd[`PIE_B1_RX] = serial_rx_full_in;
    flg1_rd[`PIE_B1_TX] = serial_tx_empty_in;
  end

  // side effect strobes to the serial block; address decode lives there
  assign serial_rx_data_rd_out = 1'b0;
  assign serial_tx_data_wr_out = 1'b0;

  // ============================================================
  // request to the core: or of pairs, then peripheral and global gates
  assign periph_pend    = |(flg1_rd & en1_q) || |(flg2_q & en2_q);
  assign periph_irq_out = periph_pend && core_q[`PIE_CORE_PERIPH];
  assign core_irq_out   = periph_irq_out && core_q[`PIE_CORE_GLOBAL];

  // ============================================================
  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (req_in.rd) begin
      case (req_in.addr)
        `PIE_OFS_EN1:  rdata_out <= en1_q;
        `PIE_OFS_EN2:  rdata_out <= en2_q;
        `PIE_OFS_FLG1: rdata_out <= flg1_rd;
        `PIE_OFS_FLG2: rdata_out <= flg2_q;
        `PIE_OFS_CORE: rdata_out <= core_q;
        default:       rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ============================================================
  // checks: gating of the request towards the core

  // a closed peripheral gate must silence both outputs
  chk_gate_blocks: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !core_q[`PIE_CORE_PERIPH] |-> !periph_irq_out && !core_irq_out)
    else $error("request passed a closed peripheral gate");

  // the core request needs the global gate on top
  chk_global_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    core_irq_out |-> core_q[`PIE_CORE_GLOBAL] && periph_pend)
    else $error("core request without global gate");

  // with both gates open the core request follows the peripheral one
  chk_core_follow: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    periph_irq_out && core_q[`PIE_CORE_GLOBAL] |-> core_irq_out)
    else $error("open global gate gave no core request");

  // the enabled and pending timer1 pair must raise the request
  chk_or_request: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    core_q[`PIE_CORE_PERIPH] && en1_q[`PIE_B1_TIMER1_COUNTER] && flg1_q[`PIE_B1_TIMER1_COUNTER]
      |-> periph_irq_out)
    else $error("enabled flag gave no request");

  // ============================================================
  // checks: enable registers

  // bank one stores the written byte as it is
  chk_en1_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_en1 |=> en1_q == $past(req_in.wdata))
    else $error("enable bank one write not stored");

  // bank two stores only its implemented bits
  chk_en2_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_en2 |=> en2_q == ($past(req_in.wdata) & `PIE_MASK2))
    else $error("enable bank two write not stored");

  // unimplemented bank two places never hold a one
  chk_unimpl_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (en2_q & ~`PIE_MASK2) == 8'h00 && (flg2_q & ~`PIE_MASK2) == 8'h00)
    else $error("unimplemented bank two bit set");

  // ============================================================
  // checks: flag bank one

  // a flag sets even with its enable and the gate closed
  chk_flag_blind: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.timer1_counter_overflow && !en1_q[`PIE_B1_TIMER1_COUNTER] && !core_q[`PIE_CORE_PERIPH]
      |=> flg1_q[`PIE_B1_TIMER1_COUNTER])
    else $error("masked timer1 event not latched");

  // eeprom write done latches its flag
  chk_eeprom_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.eeprom_done |=> flg1_q[`PIE_B1_EEPROM])
    else $error("eeprom event lost");

  // an adc event survives a same-cycle clear
  chk_set_wins: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.adc_done |=> flg1_q[`PIE_B1_ADC])
    else $error("adc event lost");

  // a software clear with no event really clears
  chk_flag_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_flg1 && !req_in.wdata[`PIE_B1_ADC] && !evt_in.adc_done |=> !flg1_q[`PIE_B1_ADC])
    else $error("adc flag not cleared by write");

  // serial bits are never stored, only mirrored
  chk_serial_unstored: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (flg1_q & ~`PIE_WMASK_FLG1) == 8'h00)
    else $error("serial flag bit stored");

  // the rx bit read back is the buffer level at the strobe
  chk_rx_mirror: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    req_in.rd && req_in.addr == `PIE_OFS_FLG1
      |=> rdata_out[`PIE_B1_RX] == $past(serial_rx_full_in))
    else $error("rx flag not mirroring buffer");

  // the tx bit read back is the buffer level at the strobe
  chk_tx_mirror: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    req_in.rd && req_in.addr == `PIE_OFS_FLG1
      |=> rdata_out[`PIE_B1_TX] == $past(serial_tx_empty_in))
    else $error("tx flag not mirroring buffer");

  // ssp transfer done latches its flag
  chk_ssp_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.ssp_done |=> flg1_q[`PIE_B1_SSP])
    else $error("ssp event lost");

  // cc1 latches in capture mode
  chk_cc1_capture: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.cc1_event && cc1_mode_in == PIE_CC_CAPTURE |=> flg1_q[`PIE_B1_CC1])
    else $error("cc1 capture event lost");

  // cc1 stays quiet in pwm mode
  chk_pwm_quiet: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !flg1_q[`PIE_B1_CC1] && cc1_mode_in == PIE_CC_PWM && !wr_flg1
      |=> !flg1_q[`PIE_B1_CC1])
    else $error("cc1 flag set in pwm mode");

  // timer2 match sets the flag and it holds one more cycle unless written
  chk_tmr2_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.tmr2_match |=> flg1_q[`PIE_B1_TMR2] ##1 flg1_q[`PIE_B1_TMR2] || $past(wr_flg1))
    else $error("timer2 flag not held");

  // timer1 overflow latches its flag
  chk_timer1_counter_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.timer1_counter_overflow |=> flg1_q[`PIE_B1_TIMER1_COUNTER])
    else $error("timer1 event lost");

  // ============================================================
  // checks: flag bank two

  // oscillator fail latches its flag
  chk_osc_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.osc_fail |=> flg2_q[`PIE_B2_OSC])
    else $error("osc fail event lost");

  // the oscillator flag only drops through a write
  chk_flag_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    flg2_q[`PIE_B2_OSC] && !wr_flg2 |=> flg2_q[`PIE_B2_OSC])
    else $error("osc fail flag dropped without write");

  // a comparator change sets its flag; history is only valid out of reset
  chk_cmp_change: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $changed(comparator_a_output_in) && $past(rst_n_in) |=> flg2_q[`PIE_B2_CMPA])
    else $error("comparator a change not flagged");

  // same for the second comparator
  chk_cmpb_change: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $changed(comparator_b_output_in) && $past(rst_n_in) |=> flg2_q[`PIE_B2_CMPB])
    else $error("comparator b change not flagged");

  // lcd request latches its flag
  chk_lcd_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.lcd_req |=> flg2_q[`PIE_B2_LCD])
    else $error("lcd request lost");

  // low voltage request latches its flag
  chk_lvd_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.lvd_req |=> flg2_q[`PIE_B2_LVD])
    else $error("low voltage request lost");

  // cc2 latches in compare mode
  chk_cc2_compare: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.cc2_event && cc2_mode_in == PIE_CC_COMPARE |=> flg2_q[`PIE_B2_CC2])
    else $error("cc2 compare event lost");

  // ============================================================
  // checks: read port

  // read data stands only in the cycle after a read strobe
  chk_rdata_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !req_in.rd |=> rdata_out == 8'h00)
    else $error("read data without read strobe");

  // ============================================================
  // main scenarios
  cov_core_irq: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    core_irq_out);
  cov_set_clear: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_flg1 && evt_in.eeprom_done);
  cov_cmp_edge: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(comparator_b_output_in));
  cov_pwm_event: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    evt_in.cc1_event && cc1_mode_in == PIE_CC_PWM);
  cov_flag2_read: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    req_in.rd && req_in.addr == `PIE_OFS_FLG2 && flg2_q != 8'h00);

endmodule

// ===== pie_defs.svh
/*
 * register offsets, field positions, masks and reset values of the
 * peripheral interrupt enable and flag bank.
 * assumes inclusion by its bare name from the package and the module.
 */
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH

// ============================================================
// register offsets on the plain register port
`define PIE_OFS_EN1      4'h0
`define PIE_OFS_EN2      4'h1
`define PIE_OFS_FLG1     4'h2
`define PIE_OFS_FLG2     4'h3
`define PIE_OFS_CORE     4'h4

// ============================================================
// bank one bit positions (shared by enables and flags)
`define PIE_B1_EEPROM    7
`define PIE_B1_ADC       6
`define PIE_B1_RX        5
`define PIE_B1_TX        4
`define PIE_B1_SSP       3
`define PIE_B1_CC1       2
`define PIE_B1_TMR2      1
`define PIE_B1_TIMER1_COUNTER      0

// ============================================================
// bank two bit positions (shared by enables and flags)
`define PIE_B2_OSC       7
`define PIE_B2_CMPB      6
`define PIE_B2_CMPA      5
`define PIE_B2_LCD       4
`define PIE_B2_LVD       2
`define PIE_B2_CC2       0

// ============================================================
// core gate register bit positions
`define PIE_CORE_GLOBAL  7
`define PIE_CORE_PERIPH  6

// ============================================================
// masks and reset values
`define PIE_MASK2        8'hf5
`define PIE_WMASK_FLG1   8'hcf
`define PIE_MASK_CORE    8'hc0
`define PIE_RST_VAL      8'h00

`endif

// ===== pie_pkg.sv
/*
 * types of the peripheral interrupt enable and flag bank.
 * assumes pie_defs.svh sits beside it.
 */
`include "pie_defs.svh"

package pie_pkg;

  // ============================================================
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pie_req_s;

  // ============================================================
  // one-cycle event pulses from the peripherals
  typedef struct packed {
    logic eeprom_done;
    logic adc_done;
    logic ssp_done;
    logic cc1_event;
    logic cc2_event;
    logic tmr2_match;
    logic timer1_counter_overflow;
    logic osc_fail;
    logic lcd_req;
    logic lvd_req;
  } pie_evt_s;

  // ============================================================
  // capture/compare unit mode
  typedef enum logic [1:0] {
    PIE_CC_CAPTURE,
    PIE_CC_COMPARE,
    PIE_CC_PWM,
    PIE_CC_OFF
  } pie_cc_mode_e;

endpackage

// ===== pie_periph_model.sv
/*
 * peripheral event sources facing the interrupt bank: event pulses and
 * serial and comparator levels, launched one cycle after the bench asks.
 * assumes the bank's clock and synchronous active low reset.
 */
`timescale 1ns/10ps

module pie_periph_model
  import pie_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // requests from the bench
  input  wire logic [9:0] fire_in,
  input  wire logic [3:0] lvl_in,
  // towards the bank
  output pie_evt_s        evt_out,
  output logic            rx_full_out,
  output logic            tx_empty_out,
  output logic            cmp_a_out,
  output logic            cmp_b_out
);
  // ==========================================================
  // one-cycle pulses; sources stay quiet while held in reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      evt_out <= '0;
    end else begin
      evt_out <= fire_in;
    end
  end

  // levels move freely, reset only stops the pulses
  always_ff @(posedge sys_clk_in) begin
    {rx_full_out, tx_empty_out, cmp_a_out, cmp_b_out} <= lvl_in;
  end
endmodule

// ===== tb.sv
/*
 * self-checking bench for the peripheral interrupt bank: random register
 * traffic and events, checked every cycle against an integer model.
 * assumes pie_bank and pie_periph_model as declared.
 */
`timescale 1ns/10ps

module tb;
  import pie_pkg::*;
  // ==========================================================
  // signals
  logic         sys_clk_in, rst_n_in, started;
  pie_req_s     req;
  pie_evt_s     evt;
  pie_cc_mode_e m1, m2;
  logic [7:0]   rdata, s1, s2;
  logic [9:0]   fire;
  logic [3:0]   lvl;
  logic         rx, tx, ca, cb, ha, hb, p_irq, c_irq, pexp;
  logic [31:0]  lfsr_st, r;
  logic         rd_side, wr_side;
  int           errors, n_tests, en1, en2, f1, f2, core, rdq;

  pie_periph_model i_pie_periph_model (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .fire_in(fire), .lvl_in(lvl), .evt_out(evt), .rx_full_out(rx), .tx_empty_out(tx),
    .cmp_a_out(ca), .cmp_b_out(cb));

  pie_bank i_pie_bank (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_in(req),
    .rdata_out(rdata), .evt_in(evt), .cc1_mode_in(m1), .cc2_mode_in(m2),
    .serial_rx_full_in(rx), .serial_tx_empty_in(tx), .comparator_a_output_in(ca),
    .comparator_b_output_in(cb), .serial_rx_data_rd_out(rd_side),
    .serial_tx_data_wr_out(wr_side),
    .periph_irq_out(p_irq), .core_irq_out(c_irq));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
    return lfsr_st;
  endfunction

  task automatic cmp_data(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_irq(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask

  task automatic end_sim();
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // reference model, stepped on the same edge as the bank
  always @(posedge sys_clk_in) begin
    s1 = {evt.eeprom_done, evt.adc_done, 2'b00, evt.ssp_done,
          evt.cc1_event && m1 inside {PIE_CC_CAPTURE, PIE_CC_COMPARE},
          evt.tmr2_match, evt.timer1_counter_overflow};
    s2 = {evt.osc_fail, cb != hb, ca != ha, evt.lcd_req, 1'b0, evt.lvd_req, 1'b0,
          evt.cc2_event && m2 inside {PIE_CC_CAPTURE, PIE_CC_COMPARE}};
    rdq = 0;
    if (!rst_n_in) begin
      {en1, en2, f1, f2, core, ha, hb} = '0;
    end else begin
      if (req.rd) begin
        case (req.addr)
          4'h0: rdq = en1;
          4'h1: rdq = en2;
          4'h2: rdq = f1 | ({rx, tx} << 4);
          4'h3: rdq = f2;
          4'h4: rdq = core;
          default: rdq = 0;
        endcase
      end
      if (req.wr) begin
        case (req.addr)
          4'h0: en1 = req.wdata;
          4'h1: en2 = req.wdata & 8'hf5;
          4'h2: f1 = req.wdata & 8'hcf;
          4'h3: f2 = req.wdata & 8'hf5;
          4'h4: core = req.wdata & 8'hc0;
          default: ;
        endcase
      end
      // sets land after the write so a same-cycle clear loses
      f1 = f1 | s1;
      f2 = f2 | s2;
      ha = ca;
      hb = cb;
    end
  end

  // settled outputs checked mid-cycle
  always @(negedge sys_clk_in) begin
    if (started) begin
      pexp = ((((f1 | ({rx, tx} << 4)) & en1) | (f2 & en2)) != 0) && core[6];
      cmp_data("read data", rdq[7:0], rdata);
      cmp_irq("periph request", pexp, p_irq);
      cmp_irq("core request", pexp && core[7], c_irq);
      cmp_irq("rx data read strobe", 1'b0, rd_side);
      cmp_irq("tx data write strobe", 1'b0, wr_side);
    end
  end

  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    #30000;
    errors++;
    end_sim();
  end

  initial begin
    {errors, n_tests, started} = '0;
    lfsr_st = 32'h958c;
    rst_n_in = 1'b0;
    req = '0;
    fire = '0;
    lvl = '0;
    m1 = PIE_CC_CAPTURE;
    m2 = PIE_CC_COMPARE;
    repeat (8) @(posedge sys_clk_in);
    started = 1'b1;
    rst_n_in <= 1'b1;
    // reset values, unmapped places included
    for (int a = 0; a < 8; a++) bus(1'b0, 1'b1, a[3:0], 8'h00);
    // stale flags cleared before their enables go up
    bus(1'b1, 1'b0, 4'h2, 8'h00);
    bus(1'b1, 1'b0, 4'h0, 8'hff);
    bus(1'b1, 1'b0, 4'h3, 8'h00);
    bus(1'b1, 1'b0, 4'h1, 8'hff);
    for (int i = 0; i < 4000; i++) begin
      @(posedge sys_clk_in);
      r = rnd();
      req <= '{addr: {1'b0, r[4:2]}, wdata: r[12:5], wr: r[1:0] == 2'd0,
               rd: r[1:0] == 2'd1};
      fire <= 10'(rnd() & rnd() & rnd());
      lvl <= lvl ^ 4'(rnd() & rnd() & rnd());
      rst_n_in <= !(i >= 2000 && i < 2003);
      if (i % 64 == 0) begin
        m1 <= pie_cc_mode_e'(r[14:13]);
        m2 <= pie_cc_mode_e'(r[16:15]);
      end
    end
    @(posedge sys_clk_in);
    req <= '0;
    repeat (2) @(posedge sys_clk_in);
    end_sim();
  end
endmodule
